// *** rate_pkg.sv ***
// Purpose: constants for the output rate decoder
// Assumes: divisor codes and prescale as used by the filter core
// Notes:   shared by the decoder, its checker and its bench
package rate_pkg;
	localparam int unsigned PRESCALE       = 128;
	localparam int unsigned CODE_W         = 12;
	localparam int unsigned WORD_W         = 24;
	localparam logic [11:0] CODE_C0_R00    = 12'h187;
	localparam logic [11:0] CODE_C0_R01    = 12'h138;
	localparam logic [11:0] CODE_C0_R10    = 12'h04e;
	localparam logic [11:0] CODE_C0_R11    = 12'h027;
	localparam logic [11:0] CODE_C1_R00    = 12'h180;
	localparam logic [11:0] CODE_C1_R01    = 12'h140;
	localparam logic [11:0] CODE_C1_R10    = 12'h04d;
	localparam logic [11:0] CODE_C1_R11    = 12'h026;
	localparam logic        HOLD_RESET     = 1'h1;
	localparam int unsigned PRE_W          = 7;
	localparam logic [6:0]  PRE_LAST       = 7'h7f;
endpackage

// *** word_buffer.sv ***
// Purpose: two-entry buffer between filter and reader
// Assumes: same clock on both sides
// Notes:   full only when both entries hold words
`timescale 1ns/100ps
module word_buffer #(
	parameter int unsigned WIDTH = 24
) (
	// clock and reset
	input  wire logic             mclk_i,
	input  wire logic             rst_i,
	// fill side
	input  wire logic             in_valid_i,
	output      logic             in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output      logic             out_valid_o,
	input  wire logic             out_ready_i,
	output      logic [WIDTH-1:0] out_data_o
);
	logic [WIDTH-1:0] mem [2];
	logic             rd_ptr;
	logic             wr_ptr;
	logic [1:0]       count;
	logic             next_rd_ptr;
	logic             next_wr_ptr;
	logic [1:0]       next_count;
	logic             do_wr;
	logic             do_rd;

	////////////////////////////////////////////////////////////////
	always_comb begin
		do_wr       = in_valid_i && (count != 2'h2);
		do_rd       = out_ready_i && (count != 2'h0);
		next_wr_ptr = do_wr ? ~wr_ptr : wr_ptr;
		next_rd_ptr = do_rd ? ~rd_ptr : rd_ptr;
		next_count  = count + {1'h0, do_wr} - {1'h0, do_rd};
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_ptr <= 1'h0;
			wr_ptr <= 1'h0;
			count  <= 2'h0;
		end else begin
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			count  <= next_count;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	assign in_ready_o  = (count != 2'h2);
	assign out_valid_o = (count != 2'h0);
	assign out_data_o  = mem[rd_ptr];
endmodule

// *** output_rate_decoder.sv ***
// Purpose: paces filter output words at mclk/128/code
// Assumes: select bits and samples come from logic on mclk_i
// Notes:   a boxcar sum stands in for the decimation filter
//          hold clears the counters and the running sum
`timescale 1ns/100ps
// Function
// R1: one output word every 128 times code master clock cycles.
// R2: clock-select 0 maps rate-select 00..11 to 391, 312, 78, 39.
// R3: clock-select 1 maps rate-select 00..11 to 384, 320, 77, 38.
// R4: fuller variant takes the divisor from a programmable filter code.
// R5: host sets clock-select 1 for 2.4576 MHz, 0 for 1 MHz.
// R6: output rate scales directly with the applied master clock.
// R7: filter nulls sit at integer multiples of the output rate.
// R8: hold bit is 1 after reset, blocking ready until cleared.
// R9: ready once per period; divisor count restarts on select change.
module output_rate_decoder
	import rate_pkg::*;
#(
	parameter int unsigned WIDTH    = WORD_W,
	parameter bit          FULL_VAR = 1'b0
) (
	// clock and reset
	input  wire logic              mclk_i,
	input  wire logic              rst_i,
	// configuration
	input  wire logic              clock_select_i,
	input  wire logic              rate_select_high_i,
	input  wire logic              rate_select_low_i,
	input  wire logic [CODE_W-1:0] filter_code_i,
	input  wire logic              hold_set_i,
	input  wire logic              hold_clear_i,
	// filter sample input
	input  wire logic [WIDTH-1:0]  sample_i,
	// result stream
	output      logic              result_ready_output_o,
	input  wire logic              result_take_i,
	output      logic [WIDTH-1:0]  result_data_o,
	// status
	output      logic              filter_hold_bit_o,
	output      logic [CODE_W-1:0] divisor_o,
	output      logic              word_dropped_o
);
	function automatic logic [CODE_W-1:0] decode(input logic clk_sel, input logic [1:0] rs);
		logic [CODE_W-1:0] c;
		c = CODE_C0_R00;
		unique case ({clk_sel, rs})
			3'h0: c = CODE_C0_R00; // see R2
			3'h1: c = CODE_C0_R01;
			3'h2: c = CODE_C0_R10;
			3'h3: c = CODE_C0_R11;
			3'h4: c = CODE_C1_R00; // see R3
			3'h5: c = CODE_C1_R01;
			3'h6: c = CODE_C1_R10;
			3'h7: c = CODE_C1_R11;
		endcase
		return c;
	endfunction

	// one sum feeds both the register and the pushed word; the register takes zero instead on a push or restart
	function automatic logic [WIDTH-1:0] add_sample(input logic [WIDTH-1:0] sum, input logic [WIDTH-1:0] smp);
		return sum + smp;
	endfunction

	localparam logic [CODE_W-1:0] MIN_CODE = {{(CODE_W - 1){1'h0}}, 1'h1};

	logic [CODE_W-1:0] code;
	logic [CODE_W-1:0] prev_code;
	logic [CODE_W-1:0] next_prev_code;
	logic              code_changed;
	logic              hold;
	logic              next_hold;
	logic [PRE_W-1:0]  pre_cnt;
	logic [PRE_W-1:0]  next_pre_cnt;
	logic              pre_wrap;
	logic [CODE_W-1:0] div_cnt;
	logic [CODE_W-1:0] next_div_cnt;
	logic              restart;
	logic              period_done;
	logic [WIDTH-1:0]  acc;
	logic [WIDTH-1:0]  next_acc;
	logic              dropped;
	logic              next_dropped;
	logic [WIDTH-1:0]  sum_now;
	logic              push_valid;
	logic              push_ready;
	logic              pop_ready;
	logic              buf_valid;

	////////////////////////////////////////////////////////////////
	// divisor selection
	always_comb begin
		if (FULL_VAR) begin
			code = filter_code_i; // see R4
		end else begin
			code = decode(clock_select_i, {rate_select_high_i, rate_select_low_i}); // see R2 R3
		end
		if (code == '0) begin
			code = MIN_CODE; // zero code would wrap to a 4096-step period
		end
	end

	////////////////////////////////////////////////////////////////
	// divisor in use; any change restarts the period
	always_comb begin
		next_prev_code = code;
		code_changed   = (code != prev_code); // see R9
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			prev_code <= '0;
		end else begin
			prev_code <= next_prev_code;
		end
	end

	////////////////////////////////////////////////////////////////
	// hold bit; set wins over clear so a host set is never lost
	always_comb begin
		next_hold = hold;
		if (hold_clear_i) begin
			next_hold = 1'h0;
		end
		if (hold_set_i) begin
			next_hold = 1'h1;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			hold <= HOLD_RESET; // see R8
		end else begin
			hold <= next_hold;
		end
	end

	////////////////////////////////////////////////////////////////
	// prescaler; all in mclk cycles, so rate tracks mclk
	always_comb begin
		restart      = code_changed || hold; // see R9
		pre_wrap     = (pre_cnt == PRE_LAST);
		next_pre_cnt = pre_cnt + 1'h1; // see R6
		if (restart) begin
			next_pre_cnt = '0;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pre_cnt <= '0;
		end else begin
			pre_cnt <= next_pre_cnt;
		end
	end

	////////////////////////////////////////////////////////////////
	// divisor count; one step per prescaler wrap
	always_comb begin
		period_done  = pre_wrap && (div_cnt == code - 1'h1); // see R1
		next_div_cnt = div_cnt;
		if (pre_wrap) begin
			next_div_cnt = period_done ? '0 : div_cnt + 1'h1;
		end
		if (restart) begin
			next_div_cnt = '0;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	////////////////////////////////////////////////////////////////
	// boxcar over one period: sinc nulls land at multiples of the rate
	always_comb begin
		sum_now      = add_sample(acc, sample_i); // see R7
		next_acc     = sum_now;
		next_dropped = 1'h0;
		push_valid   = period_done && !restart; // see R1
		if (restart || period_done) begin
			next_acc = '0;
		end
		if (push_valid && !push_ready) begin
			next_dropped = 1'h1; // reader stalled past both entries
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			acc     <= '0;
			dropped <= 1'h0;
		end else begin
			acc     <= next_acc;
			dropped <= next_dropped;
		end
	end

	////////////////////////////////////////////////////////////////
	// output buffer; a held filter neither shows nor gives up words
	always_comb begin
		pop_ready = result_take_i && !hold;
	end

	word_buffer #(
		.WIDTH (WIDTH)
	) u_buf (
		.mclk_i      (mclk_i),
		.rst_i       (rst_i),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.in_data_i   (sum_now),
		.out_valid_o (buf_valid),
		.out_ready_i (pop_ready),
		.out_data_o  (result_data_o)
	);

	assign result_ready_output_o = buf_valid && !hold; // see R8
	assign filter_hold_bit_o     = hold;
	assign divisor_o             = prev_code;
	assign word_dropped_o        = dropped;
endmodule

// *** rate_checker.sv ***
// Purpose: port checks for the rate decoder
// Assumes: FULL_VAR=0, select table in use
// Notes: bound below
`timescale 1ns/100ps
module rate_checker import rate_pkg::*; (
	input wire logic              mclk_i,
	input wire logic              rst_i,
	input wire logic              clock_select_i,
	input wire logic              rate_select_high_i,
	input wire logic              rate_select_low_i,
	input wire logic              hold_set_i,
	input wire logic              hold_clear_i,
	input wire logic              result_take_i,
	input wire logic              result_ready_output_o,
	input wire logic [WORD_W-1:0] result_data_o,
	input wire logic              filter_hold_bit_o,
	input wire logic [CODE_W-1:0] divisor_o,
	input wire logic              word_dropped_o
);
	localparam logic [11:0] TBL [8] = '{CODE_C0_R00, CODE_C0_R01, CODE_C0_R10, CODE_C0_R11,
		CODE_C1_R00, CODE_C1_R01, CODE_C1_R10, CODE_C1_R11};
	wire logic [2:0] sel = {clock_select_i, rate_select_high_i, rate_select_low_i};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	hold_after_reset_a: assert property ($fell(rst_i) |-> filter_hold_bit_o)
		else $error("hold bit low after reset");
	hold_blocks_ready_a: assert property (filter_hold_bit_o |-> !result_ready_output_o)
		else $error("ready while held");
	set_wins_a: assert property (hold_set_i |=> filter_hold_bit_o)
		else $error("hold set lost");
	clear_hold_a: assert property (hold_clear_i && !hold_set_i |=> !filter_hold_bit_o)
		else $error("hold clear lost");
	code_table_a: assert property (1'b1 |=> divisor_o == TBL[$past(sel)])
		else $error("divisor code wrong");
	ready_stands_a: assert property (result_ready_output_o && !result_take_i && !hold_set_i
		|=> result_ready_output_o && $stable(result_data_o))
		else $error("word left without take");
	no_early_word_a: assert property ($fell(filter_hold_bit_o) |-> !result_ready_output_o [*8])
		else $error("word too soon after clear");
	drop_held_a: assert property (word_dropped_o |-> !$past(filter_hold_bit_o) ##1 !word_dropped_o)
		else $error("drop pulse wrong");
endmodule
bind output_rate_decoder rate_checker rate_checker_inst (.mclk_i, .rst_i, .clock_select_i, .rate_select_high_i,
	.rate_select_low_i, .hold_set_i, .hold_clear_i, .result_take_i, .result_ready_output_o, .result_data_o,
	.filter_hold_bit_o, .divisor_o, .word_dropped_o);

// *** reader_model.sv ***
// Purpose: reader taking result words
// Assumes: stall commanded by the bench
// Notes: takes every other cycle, a slow reader
`timescale 1ns/100ps
module reader_model (
	input  wire logic mclk_i,
	input  wire logic stall_i,
	output      logic take_o
);
	initial begin
		take_o = 1'h0;
		forever @(negedge mclk_i) take_o <= !stall_i && !take_o;
	end
endmodule

// *** output_rate_decoder_tb_top.sv ***
// Purpose: bench for the rate decoder
// Assumes: FULL_VAR=0, fastest code 38
// Notes: samples held constant so a word is code*128*sample
`timescale 1ns/100ps
module output_rate_decoder_tb_top import rate_pkg::*; ;
	logic        mclk_i = 0, rst_i = 1, cs = 0, rh = 0, rl = 0, hs = 0, hc = 0, stall = 1;
	logic [23:0] smp = '0;
	logic [31:0] seed = 32'h4b;
	wire logic   rdy, take, hold, drop;
	wire logic [23:0] data;
	wire logic [11:0] div;
	int          bad_count = 0, samples_checked = 0, drops = 0, n;
	logic [23:0] exq [$];
	localparam logic [11:0] TBL [8] = '{CODE_C0_R00, CODE_C0_R01, CODE_C0_R10, CODE_C0_R11,
		CODE_C1_R00, CODE_C1_R01, CODE_C1_R10, CODE_C1_R11};
	////////////////////////////////////////////////////////////////
	output_rate_decoder #(.WIDTH(24), .FULL_VAR(1'b0)) output_rate_decoder_inst (.mclk_i(mclk_i), .rst_i(rst_i),
		.clock_select_i(cs), .rate_select_high_i(rh), .rate_select_low_i(rl), .filter_code_i(12'h000),
		.hold_set_i(hs), .hold_clear_i(hc), .sample_i(smp), .result_ready_output_o(rdy), .result_take_i(take),
		.result_data_o(data), .filter_hold_bit_o(hold), .divisor_o(div), .word_dropped_o(drop));
	reader_model reader_model_inst (.mclk_i(mclk_i), .stall_i(stall), .take_o(take));
	initial forever #2.5 mclk_i = !mclk_i;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge mclk_i) begin
		if (drop === 1'b1) drops++;
		if (rdy === 1'b1 && take === 1'b1) chk("word", data, exq.size() ? exq.pop_front() : ~data);
	end
	initial begin
		repeat (6 * PRESCALE * CODE_C1_R11) @(posedge mclk_i);
		bad_count++;
		end_sim;
	end
	initial begin
		repeat (5) @(posedge mclk_i);
		@(negedge mclk_i) rst_i = 0;
		chk("hold", {23'h0, hold}, 24'h1);
		for (int i = 0; i < 8; i++) begin
			{cs, rh, rl} = i[2:0];
			repeat (2) @(negedge mclk_i);
			chk("code", div, TBL[i]);
		end
		$display("code table done");
		seed = xs(seed);
		smp = {8'h00, seed[15:0]};
		hc = 1; // cs=1 stands for the faster clock
		@(negedge mclk_i) hc = 0;
		repeat (2) exq.push_back(smp * 24'(PRESCALE * CODE_C1_R11));
		n = 1;
		while (rdy !== 1'b1 && n < 6000) begin
			@(negedge mclk_i);
			n++;
		end
		chk("period", 24'(n), 24'(PRESCALE * CODE_C1_R11 + 1));
		repeat (2 * PRESCALE * CODE_C1_R11 + 4) @(negedge mclk_i);
		chk("drop", 24'(drops), 24'h1);
		stall <= 1'h0;
		repeat (20) @(negedge mclk_i);
		hs = 1;
		chk("drained", 24'(exq.size()), 24'h0);
		@(negedge mclk_i) hs = 0;
		chk("held", {22'h0, hold, rdy}, 24'h2);
		$display("stream test done");
		end_sim;
	end
endmodule
